// ### verilog/pmbs_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module pmbs_sequencer (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] port_control_high,
   input wire logic [7:0] port_control_low,
   input wire logic [7:0] port_mode_high,
   input wire logic [7:0] port_mode_low,
   input wire logic [15:0] pin_enable_bits,
   input wire logic irq_enable,
   input wire logic addr_load,
   input wire logic [15:0] addr_load_data,
   input wire logic sw_read_low,
   input wire logic sw_write_low,
   input wire logic [7:0] sw_wdata_low,
   input wire logic sw_write_high,
   input wire logic [7:0] sw_wdata_high,
   input wire logic [7:0] bus_data_in,
   output logic [7:0] bus_data_out,
   output logic bus_data_oe_n,
   output logic [15:0] addr_pins,
   output logic read_strobe,
   output logic write_strobe,
   output logic enable_strobe,
   output logic byte_enable_strobe,
   output logic addr_latch_low_strobe,
   output logic addr_latch_high_strobe,
   output logic chip_select_one,
   output logic chip_select_two,
   output logic [15:0] address_reg,
   output logic [7:0] input_data_low_reg,
   output logic [7:0] input_data_high_reg,
   output logic busy,
   output logic irq
);
   logic [1:0] mux_sel;
   logic [1:0] csf;
   logic [1:0] mmode;
   logic [1:0] wb;
   logic [3:0] wm;
   logic [1:0] we;
   logic wide;
   logic master_on;

   assign mux_sel = port_control_high[pmbs_pkg::PCH_MUX_HI:pmbs_pkg::PCH_MUX_LO];
   assign csf = port_control_low[pmbs_pkg::PCL_CSF_HI:pmbs_pkg::PCL_CSF_LO];
   assign mmode = port_mode_high[pmbs_pkg::PMH_MODE_HI:pmbs_pkg::PMH_MODE_LO];
   assign wide = port_mode_high[pmbs_pkg::PMH_WIDE];
   assign wb = port_mode_low[pmbs_pkg::PML_WB_HI:pmbs_pkg::PML_WB_LO];
   assign wm = port_mode_low[pmbs_pkg::PML_WM_HI:pmbs_pkg::PML_WM_LO];
   assign we = port_mode_low[pmbs_pkg::PML_WE_HI:pmbs_pkg::PML_WE_LO];
   assign master_on = port_control_high[pmbs_pkg::PCH_ENABLE] & mmode[1];

   // bus input: three stages, value taken once stages two and three agree
   logic [7:0] din_s1_reg;
   logic [7:0] din_s2_reg;
   logic [7:0] din_s3_reg;
   logic [7:0] din_reg;
   logic [7:0] din_next;

   always_comb begin
      din_next = (din_s2_reg == din_s3_reg) ? din_s3_reg : din_reg;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         din_s1_reg <= pmbs_pkg::DATA_RESET;
         din_s2_reg <= pmbs_pkg::DATA_RESET;
         din_s3_reg <= pmbs_pkg::DATA_RESET;
         din_reg <= pmbs_pkg::DATA_RESET;
      end else begin
         din_s1_reg <= bus_data_in;
         din_s2_reg <= din_s1_reg;
         din_s3_reg <= din_s2_reg;
         din_reg <= din_next;
      end
   end

   // sequencer
   pmbs_pkg::pmbs_state_t state_reg;
   pmbs_pkg::pmbs_state_t state_next;
   logic second_reg;
   logic second_next;
   logic dir_wr_reg;
   logic dir_wr_next;
   logic phase_last;
   logic op_last;
   logic accept;
   logic trig;
   logic [3:0] tload_val;
   logic [15:0] addr_stepped;
   logic [15:0] address_next;
   logic [7:0] low_next;
   logic [7:0] high_next;
   logic irq_next;
   pmbs_pkg::pmbs_state_t data_start;
   pmbs_pkg::pmbs_state_t op_start;

   pmbs_wait_timer u_timer (
      .clk(clk),
      .rstn(rstn),
      .load(phase_last | (state_reg == pmbs_pkg::S_IDLE)),
      .load_val(tload_val),
      .last(phase_last)
   );

   pmbs_addr_step u_step (
      .addr(address_reg),
      .inc_mode(port_mode_high[pmbs_pkg::PMH_INC_HI:pmbs_pkg::PMH_INC_LO]),
      .cs_func(csf),
      .addr_stepped(addr_stepped)
   );

   always_comb begin
      // zero middle wait means a bare one-cycle strobe
      if (wm != 4'h0 && wb != 2'h0) begin
         data_start = pmbs_pkg::S_SETUP;
      end else begin
         data_start = pmbs_pkg::S_STROBE;
      end
      if (mux_sel == pmbs_pkg::MUX_PART || mux_sel == pmbs_pkg::MUX_FULL) begin
         op_start = pmbs_pkg::S_ADRL;
      end else begin
         op_start = data_start;
      end
      op_last = 1'b0;
      if (wide == second_reg || !wide) begin
         if (state_reg == pmbs_pkg::S_HOLD) begin
            op_last = phase_last;
         end else if (state_reg == pmbs_pkg::S_STROBE) begin
            op_last = phase_last & ~(wm != 4'h0 && we != 2'h0);
         end
      end
      busy = (state_reg != pmbs_pkg::S_IDLE) & ~op_last;
      trig = sw_read_low | sw_write_low;
      accept = master_on & trig & ~busy;
      state_next = state_reg;
      second_next = second_reg;
      dir_wr_next = dir_wr_reg;
      if (accept) begin
         dir_wr_next = sw_write_low;
      end
      case (state_reg)
         pmbs_pkg::S_IDLE: begin
            if (accept) begin
               state_next = op_start;
               second_next = 1'b0;
            end
         end
         pmbs_pkg::S_ADRL: begin
            if (mux_sel == pmbs_pkg::MUX_FULL) begin
               state_next = pmbs_pkg::S_ADRH;
            end else begin
               state_next = data_start;
            end
         end
         pmbs_pkg::S_ADRH: state_next = data_start;
         pmbs_pkg::S_SETUP: begin
            if (phase_last) begin
               state_next = pmbs_pkg::S_STROBE;
            end
         end
         pmbs_pkg::S_STROBE, pmbs_pkg::S_HOLD: begin
            if (op_last) begin
               state_next = accept ? op_start : pmbs_pkg::S_IDLE;
               second_next = 1'b0;
            end else if (state_reg == pmbs_pkg::S_STROBE && phase_last &&
                         wm != 4'h0 && we != 2'h0) begin
               state_next = pmbs_pkg::S_HOLD;
            end else if (phase_last) begin
               state_next = data_start;
               second_next = 1'b1;
            end
         end
         default: state_next = pmbs_pkg::S_IDLE;
      endcase
      case (state_next)
         pmbs_pkg::S_SETUP: tload_val = {2'h0, wb} - 4'h1;
         pmbs_pkg::S_STROBE: tload_val = (wm == 4'h0) ? 4'h0 : wm - 4'h1;
         pmbs_pkg::S_HOLD: tload_val = {2'h0, we} - 4'h1;
         default: tload_val = 4'h0;
      endcase
   end

   // registers seen by software; stale read value is what software expects
   always_comb begin
      address_next = address_reg;
      if (op_last) begin
         address_next = addr_stepped;
      end else if (addr_load && !busy) begin
         address_next = addr_load_data;
      end
      low_next = input_data_low_reg;
      high_next = sw_write_high ? sw_wdata_high : input_data_high_reg;
      if (accept && sw_write_low) begin
         low_next = sw_wdata_low;
      end
      if (state_reg == pmbs_pkg::S_STROBE && phase_last && !dir_wr_reg) begin
         if (second_reg) begin
            high_next = din_reg;
         end else begin
            low_next = din_reg;
         end
      end
      irq_next = op_last & irq_enable;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= pmbs_pkg::S_IDLE;
         second_reg <= 1'b0;
         dir_wr_reg <= 1'b0;
         address_reg <= pmbs_pkg::ADDR_RESET;
         input_data_low_reg <= pmbs_pkg::DATA_RESET;
         input_data_high_reg <= pmbs_pkg::DATA_RESET;
         irq <= 1'b0;
      end else begin
         state_reg <= state_next;
         second_reg <= second_next;
         dir_wr_reg <= dir_wr_next;
         address_reg <= address_next;
         input_data_low_reg <= low_next;
         input_data_high_reg <= high_next;
         irq <= irq_next;
      end
   end

   // pin outputs, registered from the next state so they line up with it
   logic [7:0] dout_next;
   logic doe_n_next;
   logic [15:0] apin_next;
   logic rd_next, wr_next, en_next, be_next, all_next, alh_next, cs1_next, cs2_next;
   logic in_op;
   logic strobing;
   logic [15:0] addr_hi_masked;

   always_comb begin
      in_op = (state_next != pmbs_pkg::S_IDLE);
      strobing = (state_next == pmbs_pkg::S_STROBE);
      addr_hi_masked = address_next;
      if (csf != pmbs_pkg::CSF_NONE) begin
         addr_hi_masked[pmbs_pkg::ADDR_CS2_BIT] = 1'b0;
      end
      if (csf != pmbs_pkg::CSF_NONE && csf != pmbs_pkg::CSF_CS2) begin
         addr_hi_masked[pmbs_pkg::ADDR_CS1_BIT] = 1'b0;
      end
      all_next = (state_next == pmbs_pkg::S_ADRL);
      alh_next = (state_next == pmbs_pkg::S_ADRH);
      doe_n_next = 1'b1;
      dout_next = bus_data_out;
      if (all_next) begin
         dout_next = address_next[7:0];
         doe_n_next = 1'b0;
      end else if (alh_next) begin
         dout_next = addr_hi_masked[15:8];
         doe_n_next = 1'b0;
      end else if (in_op && dir_wr_next) begin
         dout_next = second_next ? high_next : low_next;
         doe_n_next = 1'b0;
      end
      apin_next = addr_hi_masked;
      if (mux_sel == pmbs_pkg::MUX_PART || mux_sel == pmbs_pkg::MUX_FULL) begin
         apin_next[0] = all_next;
      end
      if (mux_sel == pmbs_pkg::MUX_FULL) begin
         apin_next[1] = alh_next;
         apin_next[15:8] = addr_hi_masked[15:8] & 8'h00;
      end
      cs2_next = in_op & (csf != pmbs_pkg::CSF_NONE) & address_next[pmbs_pkg::ADDR_CS2_BIT];
      cs1_next = in_op & (csf != pmbs_pkg::CSF_NONE) & (csf != pmbs_pkg::CSF_CS2) &
                 address_next[pmbs_pkg::ADDR_CS1_BIT];
      apin_next[pmbs_pkg::ADDR_CS2_BIT] = (csf == pmbs_pkg::CSF_NONE) ?
                                          apin_next[pmbs_pkg::ADDR_CS2_BIT] : cs2_next;
      if (csf != pmbs_pkg::CSF_NONE && csf != pmbs_pkg::CSF_CS2) begin
         apin_next[pmbs_pkg::ADDR_CS1_BIT] = cs1_next;
      end
      apin_next = apin_next & pin_enable_bits;
      if (mmode == pmbs_pkg::MODE_ENABLE) begin
         rd_next = in_op & ~dir_wr_next;
         wr_next = 1'b0;
         en_next = strobing;
      end else begin
         rd_next = strobing & ~dir_wr_next;
         wr_next = strobing & dir_wr_next;
         en_next = 1'b0;
      end
      rd_next = rd_next & port_control_high[pmbs_pkg::PCH_RD_EN];
      wr_next = wr_next & port_control_high[pmbs_pkg::PCH_WR_EN];
      be_next = in_op & second_next & port_control_high[pmbs_pkg::PCH_BE_EN];
      all_next = all_next & pin_enable_bits[0];
      alh_next = alh_next & pin_enable_bits[1];
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bus_data_out <= pmbs_pkg::DATA_RESET;
         bus_data_oe_n <= 1'b1;
         addr_pins <= pmbs_pkg::ADDR_RESET;
         read_strobe <= 1'b0;
         write_strobe <= 1'b0;
         enable_strobe <= 1'b0;
         byte_enable_strobe <= 1'b0;
         addr_latch_low_strobe <= 1'b0;
         addr_latch_high_strobe <= 1'b0;
         chip_select_one <= 1'b0;
         chip_select_two <= 1'b0;
      end else begin
         bus_data_out <= dout_next;
         bus_data_oe_n <= doe_n_next;
         addr_pins <= apin_next;
         read_strobe <= rd_next;
         write_strobe <= wr_next;
         enable_strobe <= en_next;
         byte_enable_strobe <= be_next;
         addr_latch_low_strobe <= all_next;
         addr_latch_high_strobe <= alh_next;
         chip_select_one <= cs1_next;
         chip_select_two <= cs2_next;
      end
   end

   property p_idle_not_busy;
      @(posedge clk) disable iff (!rstn) (state_reg == pmbs_pkg::S_IDLE) |-> !busy;
   endproperty
   a_idle_not_busy: assert property (p_idle_not_busy) else $error("busy while idle");

   property p_busy_ignores;
      @(posedge clk) disable iff (!rstn) busy |=> $stable(dir_wr_reg);
   endproperty
   a_busy_ignores: assert property (p_busy_ignores) else $error("request taken while busy");

   property p_part_one_cycle;
      @(posedge clk) disable iff (!rstn)
         (accept && state_reg == pmbs_pkg::S_IDLE && mux_sel == pmbs_pkg::MUX_PART)
         |=> (state_reg == pmbs_pkg::S_ADRL) ##1 (state_reg != pmbs_pkg::S_ADRL);
   endproperty
   a_part_one_cycle: assert property (p_part_one_cycle) else $error("partial address cycle");

   property p_full_two_cycles;
      @(posedge clk) disable iff (!rstn)
         (state_reg == pmbs_pkg::S_ADRL && mux_sel == pmbs_pkg::MUX_FULL)
         |=> (state_reg == pmbs_pkg::S_ADRH) ##1 (state_reg != pmbs_pkg::S_ADRH);
   endproperty
   a_full_two_cycles: assert property (p_full_two_cycles) else $error("full address cycles");

   property p_low_addr_out;
      @(posedge clk) disable iff (!rstn)
         (state_reg == pmbs_pkg::S_ADRL) |-> (!bus_data_oe_n && bus_data_out == address_reg[7:0]);
   endproperty
   a_low_addr_out: assert property (p_low_addr_out) else $error("low address not on data");

   property p_cs_zero;
      @(posedge clk) disable iff (!rstn)
         (state_reg == pmbs_pkg::S_ADRH && $past(csf) != pmbs_pkg::CSF_NONE) |-> !bus_data_out[7];
   endproperty
   a_cs_zero: assert property (p_cs_zero) else $error("chip select bit in high byte");

   property p_step_up;
      @(posedge clk) disable iff (!rstn)
         (op_last && csf == pmbs_pkg::CSF_NONE &&
          port_mode_high[pmbs_pkg::PMH_INC_HI:pmbs_pkg::PMH_INC_LO] == pmbs_pkg::INC_UP)
         |=> address_reg == $past(address_reg) + 16'h0001;
   endproperty
   a_step_up: assert property (p_step_up) else $error("address not incremented");

   property p_fast_strobe;
      @(posedge clk) disable iff (!rstn)
         (accept && state_reg == pmbs_pkg::S_IDLE && mux_sel == pmbs_pkg::MUX_NONE &&
          wm == 4'h0 && !wide) |=> (state_reg == pmbs_pkg::S_STROBE && !busy);
   endproperty
   a_fast_strobe: assert property (p_fast_strobe) else $error("single cycle op not bare");

   property p_irq_done;
      @(posedge clk) disable iff (!rstn) (op_last && irq_enable) |=> irq;
   endproperty
   a_irq_done: assert property (p_irq_done) else $error("no completion request");

   property p_be_second;
      @(posedge clk) disable iff (!rstn)
         byte_enable_strobe |-> (second_reg && state_reg != pmbs_pkg::S_IDLE);
   endproperty
   a_be_second: assert property (p_be_second) else $error("byte enable on first byte");
endmodule
`default_nettype wire

// ### verilog/pmbs_pkg.sv
// What this block does
// - address multiplex field sits at port control high bits 4:3.
// - field 00 keeps data and all sixteen address bits on separate lines.
// - field 01 puts low address on data lines, latch strobe on pin 0.
// - partial multiplex adds one whole cycle carrying the low address byte.
// - field 10 adds two cycles: low byte with low strobe, high with high.
// - chip select bit positions read as zero in the multiplexed high byte.
// - two chip selects share high address bits 6 and 7, skipped by stepping.
// - chip select function field sits at port control low bits 7:6.
// - address steps once per operation, when it completes and busy drops.
// - chip select bits used as address take part in stepping, else stay.
// - begin wait field bits 7:6 sets setup cycles before the strobe.
// - middle wait field bits 5:2 sets strobe length; zero voids begin/end.
// - end wait field bits 1:0 sets hold cycles after the strobe.
// - software read of input data low starts a bus read, byte stored low.
// - wide data mode: one read does two bus reads, low then high.
// - software write of input data low starts a bus write of that byte.
// - wide data mode: one write does two bus writes, low then high.
// - busy is set every operation cycle but the last.
// - while busy, new reads or writes of input data low are ignored.
// - with interrupt enabled, every completed operation raises a request.
// - wide mode sends low byte first, byte enable while high byte is out.
// - master mode 3 uses direction plus enable strobe; mode 2 separate strobes.
// - each pin enable bit routes its function to the address pin, else the pin holds zero.
package pmbs_pkg;
   localparam int PCH_ENABLE = 7;
   localparam int PCH_MUX_HI = 4;
   localparam int PCH_MUX_LO = 3;
   localparam int PCH_BE_EN = 2;
   localparam int PCH_WR_EN = 1;
   localparam int PCH_RD_EN = 0;
   localparam int PCL_CSF_HI = 7;
   localparam int PCL_CSF_LO = 6;
   localparam int PMH_INC_HI = 4;
   localparam int PMH_INC_LO = 3;
   localparam int PMH_WIDE = 2;
   localparam int PMH_MODE_HI = 1;
   localparam int PMH_MODE_LO = 0;
   localparam int PML_WB_HI = 7;
   localparam int PML_WB_LO = 6;
   localparam int PML_WM_HI = 5;
   localparam int PML_WM_LO = 2;
   localparam int PML_WE_HI = 1;
   localparam int PML_WE_LO = 0;
   localparam int ADDR_CS1_BIT = 14;
   localparam int ADDR_CS2_BIT = 15;
   localparam logic [1:0] MUX_NONE = 2'h0;
   localparam logic [1:0] MUX_PART = 2'h1;
   localparam logic [1:0] MUX_FULL = 2'h2;
   localparam logic [1:0] CSF_NONE = 2'h0;
   localparam logic [1:0] CSF_CS2 = 2'h1;
   localparam logic [1:0] INC_UP = 2'h1;
   localparam logic [1:0] INC_DOWN = 2'h2;
   localparam logic [1:0] MODE_SEPARATE = 2'h2;
   localparam logic [1:0] MODE_ENABLE = 2'h3;
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [7:0] DATA_RESET = 8'h00;
   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_ADRL = 6'h02,
      S_ADRH = 6'h04,
      S_SETUP = 6'h08,
      S_STROBE = 6'h10,
      S_HOLD = 6'h20
   } pmbs_state_t;
endpackage

// ### verilog/pmbs_wait_timer.sv
`timescale 1ns/1ns
`default_nettype none
module pmbs_wait_timer (
   input wire logic clk,
   input wire logic rstn,
   input wire logic load,
   input wire logic [3:0] load_val,
   output logic last
);
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;

   always_comb begin
      if (load) begin
         cnt_next = load_val;
      end else if (cnt_reg != 4'h0) begin
         cnt_next = cnt_reg - 4'h1;
      end else begin
         cnt_next = cnt_reg;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= 4'h0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign last = (cnt_reg == 4'h0);
endmodule
`default_nettype wire

// ### verilog/pmbs_addr_step.sv
`timescale 1ns/1ns
`default_nettype none
module pmbs_addr_step (
   input wire logic [15:0] addr,
   input wire logic [1:0] inc_mode,
   input wire logic [1:0] cs_func,
   output logic [15:0] addr_stepped
);
   // chip select bits held, the rest wraps inside its own width
   function automatic logic [15:0] cs_mask(input logic [1:0] csf);
      if (csf == pmbs_pkg::CSF_NONE) begin
         cs_mask = 16'h0000;
      end else if (csf == pmbs_pkg::CSF_CS2) begin
         cs_mask = 16'h8000;
      end else begin
         cs_mask = 16'hC000;
      end
   endfunction

   logic [15:0] raw;
   logic [15:0] keep;

   always_comb begin
      keep = cs_mask(cs_func);
      case (inc_mode)
         pmbs_pkg::INC_UP: raw = addr + 16'h0001;
         pmbs_pkg::INC_DOWN: raw = addr - 16'h0001;
         default: raw = addr;
      endcase
      addr_stepped = (addr & keep) | (raw & ~keep);
   end
endmodule
`default_nettype wire

// ### bench/pmbs_ext_mem.sv
`timescale 1ns/1ns
`default_nettype none
module pmbs_ext_mem (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] bus_data_out,
   input wire logic bus_data_oe_n,
   input wire logic addr_latch_low_strobe,
   input wire logic addr_latch_high_strobe,
   input wire logic chip_select_one,
   input wire logic byte_enable_strobe,
   output logic [7:0] bus_data_in
);
   logic [7:0] lat_lo_reg;
   logic [7:0] lat_hi_reg;
   logic [7:0] last_reg;
   logic [7:0] ans;
   // answer folds both latched bytes, high lane inverted
   assign ans = lat_lo_reg ^ lat_hi_reg ^ {8{byte_enable_strobe}};
   // unselected or overdriven: inverse of last value, so no stale byte passes
   assign bus_data_in = (chip_select_one && bus_data_oe_n) ? ans : ~last_reg;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lat_lo_reg <= 8'h00;
         lat_hi_reg <= 8'h00;
         last_reg <= 8'h00;
      end else begin
         if (addr_latch_low_strobe) lat_lo_reg <= bus_data_out;
         if (addr_latch_high_strobe) lat_hi_reg <= bus_data_out;
         last_reg <= bus_data_in;
      end
   end
endmodule
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk, rstn, irq_en, ald, rd, wr, wrh, oe_n, rs, ws, es, bes, als, ahs, cs1, cs2, busy, irq;
   logic [1:0] s_cs;
   logic [7:0] pch, pcl, pmh, pml, wd, wdh, bdi, bdo, idl, idh, s_al, s_ah;
   logic [15:0] pen, ald_d, ap, areg, s_addr;
   logic [7:0] wq[$];
   int n_mismatch, checks, cyc, n_rd, n_wr, n_en, n_be, n_al, n_ah, n_busy, n_irq;
   pmbs_sequencer u_dut (.clk(clk), .rstn(rstn), .port_control_high(pch),
      .port_control_low(pcl), .port_mode_high(pmh), .port_mode_low(pml),
      .pin_enable_bits(pen), .irq_enable(irq_en), .addr_load(ald), .addr_load_data(ald_d),
      .sw_read_low(rd), .sw_write_low(wr), .sw_wdata_low(wd), .sw_write_high(wrh),
      .sw_wdata_high(wdh), .bus_data_in(bdi), .bus_data_out(bdo), .bus_data_oe_n(oe_n),
      .addr_pins(ap), .read_strobe(rs), .write_strobe(ws), .enable_strobe(es),
      .byte_enable_strobe(bes), .addr_latch_low_strobe(als), .addr_latch_high_strobe(ahs),
      .chip_select_one(cs1), .chip_select_two(cs2), .address_reg(areg),
      .input_data_low_reg(idl), .input_data_high_reg(idh), .busy(busy), .irq(irq));
   pmbs_ext_mem u_mem (.clk(clk), .rstn(rstn), .bus_data_out(bdo), .bus_data_oe_n(oe_n),
      .addr_latch_low_strobe(als), .addr_latch_high_strobe(ahs), .chip_select_one(cs1),
      .byte_enable_strobe(bes), .bus_data_in(bdi));
   always #5 clk = ~clk;
   task results;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // monitor counts cycles of each strobe pin, busy and irq over one operation
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         results();
      end
      n_rd += rs;
      n_wr += ws;
      n_en += es;
      n_be += bes;
      n_al += als;
      n_ah += ahs;
      n_busy += busy;
      n_irq += irq;
      if (ws || es) begin
         s_addr = ap;
         s_cs = {cs2, cs1};
         wq.push_back(bdo);
      end
      if (als) s_al = bdo;
      if (ahs) s_ah = bdo;
   end
   task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task cfg(input logic [7:0] a, b, c, d, input logic [15:0] ad);
      pch = a;
      pcl = b;
      pmh = c;
      pml = d;
      ald = 1'b1;
      ald_d = ad;
      @(posedge clk);
      #1;
      ald = 1'b0;
   endtask
   // poke: a write trigger in mid-operation that must be dropped
   task op(input logic is_rd, input logic [7:0] d, input logic poke);
      int i;
      {n_rd, n_wr, n_en, n_be, n_al, n_ah, n_busy, n_irq} = '0;
      wq.delete();
      wd = d;
      if (is_rd) rd = 1'b1;
      else wr = 1'b1;
      @(posedge clk);
      #1;
      rd = 1'b0;
      wr = 1'b0;
      for (i = 0; i < 40 && busy !== 1'b0; i++) begin
         if (poke && i == 2) begin
            wr = 1'b1;
            wd = 8'h77;
         end else wr = 1'b0;
         @(posedge clk);
         #1;
      end
      wr = 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask
   initial begin
      int k;
      {clk, rstn, pch, pcl, pmh, pml, ald, ald_d, rd, wr, wd, wrh, wdh} = '0;
      pen = 16'hFFFF;
      irq_en = 1'b1;
      repeat (16) @(posedge clk);
      #1;
      rstn = 1'b1;
      cfg(8'h87, 8'h00, 8'h0A, 8'h00, 16'h12FE);
      op(1'b0, 8'h5A, 1'b0);
      check("wr_len", n_wr, 1);
      check("busy", n_busy, 0);
      check("irq", n_irq, 1);
      check("addr", s_addr, 16'h12FE);
      check("wdata", wq[0], 8'h5A);
      check("step_up", areg, 16'h12FF);
      $display("test demux_write done");
      wdh = 8'hC3;
      wrh = 1'b1;
      @(posedge clk);
      #1;
      wrh = 1'b0;
      cfg(8'h87, 8'h80, 8'h17, 8'h00, 16'h40A5);
      pen = 16'h00FF;
      op(1'b0, 8'h3C, 1'b0);
      check("en_len", n_en, 2);
      check("wr_pin", n_wr, 0);
      check("be_len", n_be, 1);
      check("lo_first", wq[0], 8'h3C);
      check("hi_second", wq[1], 8'hC3);
      check("pin_mask", s_addr, 16'h00A5);
      check("cs_pins", s_cs, 2'h1);
      check("step_down", areg, 16'h40A4);
      pen = 16'hFFFF;
      $display("test wide_write done");
      cfg(8'h97, 8'h80, 8'h06, 8'hC8, 16'h4012);
      op(1'b1, 8'h00, 1'b1);
      check("al_len", n_al, 1);
      check("ah_len", n_ah, 1);
      check("al_byte", s_al, 8'h12);
      check("ah_byte", s_ah, 8'h00);
      check("rd_len", n_rd, 4);
      check("be_len", n_be, 5);
      check("busy", n_busy, 11);
      check("ignored", n_wr, 0);
      check("irq", n_irq, 1);
      check("in_lo", idl, 8'h12);
      check("in_hi", idh, 8'hED);
      check("no_step", areg, 16'h4012);
      $display("test full_mux_read done");
      for (k = 0; k < 2; k++) begin
         cfg(8'h8F, k ? 8'h80 : 8'h00, 8'h12, 8'h00, 16'h4000);
         op(1'b0, 8'hA1, 1'b0);
         check("al_len", n_al, 1);
         check("al_byte", s_al, 8'h00);
         check("busy", n_busy, 1);
         check("hi_pins", s_addr[15:8], 8'h40);
         check("cs_pins", s_cs, k ? 2'h1 : 2'h0);
         check("cs_step", areg, k ? 16'h7FFF : 16'h3FFF);
      end
      $display("test partial_mux done");
      for (k = 0; k < 2; k++) begin
         irq_en = (k == 0);
         cfg(8'h87, 8'h00, 8'h02, k ? 8'hC3 : 8'h8D, 16'h0010);
         op(1'b0, 8'h0F, 1'b0);
         check("wr_len", n_wr, k ? 1 : 3);
         check("busy", n_busy, k ? 0 : 5);
         check("irq", n_irq, k ? 0 : 1);
      end
      $display("test wait_states done");
      results();
   end
endmodule
`default_nettype wire
